// ---- ecwas_top.sv ----
// Purpose: indirect configuration window and uncorrectable error status
// Assumes: one configuration request per cycle, answered the next cycle
// Notes:   unimplemented offsets read zero and ignore writes
`include "ecwas_cfg.svh"
module ecwas_top (
    // clock and resets
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   por_rst,
    // configuration requests
    input  wire logic                   cfg_req,
    input  wire logic                   cfg_wr,
    input  wire logic                   cfg_smbus,
    input  wire ecwas_pkg::ecwas_addr_t cfg_addr,
    input  wire ecwas_pkg::ecwas_be_t   cfg_be,
    input  wire ecwas_pkg::ecwas_word_t cfg_wdata,
    // configuration answers
    output logic                        cfg_ack_ff,
    output ecwas_pkg::ecwas_word_t      cfg_rdata_ff,
    // capability controls
    input  wire logic                   nxt_ptr_lock,
    input  wire logic                   surprise_down_capable,
    // detected errors, one-cycle pulses
    input  wire logic                   evt_link_protocol_error,
    input  wire logic                   evt_surprise_down_error,
    input  wire logic                   evt_poisoned_tlp,
    input  wire logic                   evt_flow_control_error,
    input  wire logic                   evt_unexpected_completion,
    input  wire logic                   evt_receiver_overflow,
    input  wire logic                   evt_malformed_tlp,
    input  wire logic                   evt_ecrc_error,
    input  wire logic                   evt_unsupported_request,
    // unmasked events, one-cycle pulses
    output ecwas_pkg::ecwas_word_t      err_report_ff
);
    import ecwas_pkg::*;

    localparam ecwas_addr_t OFF_ADDR   = `ECWAS_OFF_ADDR;
    localparam ecwas_addr_t OFF_DATA   = `ECWAS_OFF_DATA;
    localparam ecwas_addr_t OFF_CAP    = `ECWAS_OFF_CAP;
    localparam ecwas_addr_t OFF_STAT   = `ECWAS_OFF_STAT;
    localparam ecwas_addr_t OFF_MASK   = `ECWAS_OFF_MASK;
    localparam ecwas_word_t ADDR_WMASK = `ECWAS_ADDR_WMASK;
    localparam ecwas_word_t ERR_WMASK  = `ECWAS_ERR_WMASK;
    localparam int          RL         = `ECWAS_REG_LSB;
    localparam int          EM         = `ECWAS_EXTENDED_SELECT_MSB;

    ecwas_acc_if acc ();

    ecwas_addr_t req_dw;
    ecwas_addr_t ptr_dw;
    ecwas_addr_t eff_addr;
    ecwas_tgt_t  tgt;
    ecwas_word_t bmask;
    ecwas_word_t rd_word;
    ecwas_word_t err_evt;
    ecwas_word_t nxt_rdata;
    logic        nxt_ack;

    function automatic ecwas_word_t be_to_mask(input ecwas_be_t be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // low two address bits never select anything
    assign req_dw = {cfg_addr[EM:RL], 2'b00};
    assign ptr_dw = {acc.addr_q[EM:RL], 2'b00};
    assign bmask  = be_to_mask(cfg_be);

    // resolve the window to the register it finally reaches
    always_comb begin
        eff_addr = req_dw;
        if (req_dw == OFF_DATA && !cfg_smbus) begin
            eff_addr = ptr_dw;
        end
        case (eff_addr)
            OFF_ADDR: begin
                tgt = tgt_addr;
            end
            OFF_DATA: begin
                // reached from SMBus or from a self-pointing window
                tgt = tgt_null;
            end
            OFF_CAP: begin
                tgt = tgt_cap;
            end
            OFF_STAT: begin
                tgt = tgt_stat;
            end
            OFF_MASK: begin
                tgt = tgt_mask;
            end
            default: begin
                tgt = tgt_none;
            end
        endcase
    end

    // writes go through with the requester's byte enables
    assign acc.wr_stb = cfg_req && cfg_wr && (tgt != tgt_null)
                        && (tgt != tgt_none);
    assign acc.addr   = eff_addr;
    assign acc.bmask  = bmask;
    assign acc.wdata  = cfg_wdata;

    always_comb begin
        case (tgt)
            tgt_addr: begin
                rd_word = acc.addr_q & ADDR_WMASK;
            end
            tgt_cap: begin
                rd_word = {acc.next_capability_pointer_q, `ECWAS_CAP_VER,
                           `ECWAS_CAP_ID};
            end
            tgt_stat: begin
                rd_word = acc.status_q & ERR_WMASK;
            end
            tgt_mask: begin
                rd_word = acc.mask_q & ERR_WMASK;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // answer group; disabled lanes read zero like untouched bytes
    always_comb begin
        nxt_ack   = cfg_req;
        nxt_rdata = cfg_rdata_ff;
        if (cfg_req) begin
            nxt_rdata = cfg_wr ? '0 : (rd_word & bmask);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_ack_ff   <= 1'b0;
            cfg_rdata_ff <= '0;
        end else begin
            cfg_ack_ff   <= nxt_ack;
            cfg_rdata_ff <= nxt_rdata;
        end
    end

    // place each detected error at its status position
    always_comb begin
        err_evt = '0;
        err_evt[`ECWAS_B_DLP]  = evt_link_protocol_error;
        err_evt[`ECWAS_B_SDN]  = evt_surprise_down_error;
        err_evt[`ECWAS_B_PSN]  = evt_poisoned_tlp;
        err_evt[`ECWAS_B_FCP]  = evt_flow_control_error;
        err_evt[`ECWAS_B_UEC]  = evt_unexpected_completion;
        err_evt[`ECWAS_B_ROV]  = evt_receiver_overflow;
        err_evt[`ECWAS_B_MAL]  = evt_malformed_tlp;
        err_evt[`ECWAS_B_ECRC] = evt_ecrc_error;
        err_evt[`ECWAS_B_UR]   = evt_unsupported_request;
    end

    ecwas_win_regs u_win (
        .clk      (clk),
        .srst     (srst),
        .acc      (acc),
        .nxt_lock (nxt_ptr_lock)
    );

    ecwas_err_bits u_err (
        .clk        (clk),
        .por_rst    (por_rst),
        .acc        (acc),
        .err_evt    (err_evt),
        .sd_capable (surprise_down_capable),
        .report_ff  (err_report_ff)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || por_rst);

    sequence s_win_read;
        cfg_req && !cfg_wr && !cfg_smbus && req_dw == OFF_DATA;
    endsequence

    sequence s_win_write;
        cfg_req && cfg_wr && !cfg_smbus && req_dw == OFF_DATA;
    endsequence

    sequence s_point_at_stat;
        cfg_req && cfg_wr && req_dw == OFF_ADDR && cfg_be == 4'hF
        && cfg_wdata[11:0] == OFF_STAT;
    endsequence

    a_ack_next_cycle: assert property (
        1'b1 |=> cfg_ack_ff == $past(cfg_req))
        else $error("answer not one cycle after request");

    a_win_read_stat: assert property (
        (s_win_read and (ptr_dw == OFF_STAT && cfg_be == 4'hF))
        |=> cfg_rdata_ff == $past(acc.status_q))
        else $error("window read of status wrong");

    a_point_then_read: assert property (
        s_point_at_stat ##1 (s_win_read and (cfg_be == 4'hF))
        |=> cfg_rdata_ff == $past(acc.status_q))
        else $error("pointing then reading failed");

    a_win_read_lanes: assert property (
        (s_win_read and (ptr_dw == OFF_CAP && cfg_be == 4'h1))
        |=> cfg_rdata_ff == 32'h0000_0001)
        else $error("byte enables not applied to window read");

    a_self_read_zero: assert property (
        (s_win_read and (ptr_dw == OFF_DATA)) |=> cfg_rdata_ff == '0)
        else $error("self-pointing read not zero");

    a_self_write_drop: assert property (
        (s_win_write and (ptr_dw == OFF_DATA))
        |=> $stable(acc.addr_q) && $stable(acc.mask_q)
            && $stable(acc.next_capability_pointer_q))
        else $error("self-pointing write took effect");

    a_win_write_addr: assert property (
        (s_win_write and (ptr_dw == OFF_ADDR && cfg_be == 4'hF))
        |=> acc.addr_q == ($past(cfg_wdata) & ADDR_WMASK))
        else $error("window write of address register wrong");

    a_win_write_mask: assert property (
        (s_win_write and (ptr_dw == OFF_MASK && cfg_be == 4'hF))
        |=> acc.mask_q == ($past(cfg_wdata) & ERR_WMASK))
        else $error("window write of mask register wrong");

    a_smbus_read_zero: assert property (
        cfg_req && !cfg_wr && cfg_smbus && req_dw == OFF_DATA
        |=> cfg_rdata_ff == '0)
        else $error("SMBus data read not zero");

    a_smbus_write_drop: assert property (
        cfg_req && cfg_wr && cfg_smbus && req_dw == OFF_DATA
        |=> $stable(acc.addr_q) && $stable(acc.mask_q)
            && $stable(acc.next_capability_pointer_q))
        else $error("SMBus data write took effect");

    a_cap_header: assert property (
        cfg_req && !cfg_wr && req_dw == OFF_CAP && cfg_be == 4'hF
        |=> cfg_rdata_ff[19:0] == 20'h1_0001)
        else $error("capability id or version wrong");

    a_ro_bits_zero: assert property (
        acc.status_q[`ECWAS_B_CAB:`ECWAS_B_CTO] == 2'b00)
        else $error("read-only status bits set");

    a_flow_err_sets: assert property (
        evt_flow_control_error |=> acc.status_q[`ECWAS_B_FCP])
        else $error("flow control error not recorded");
endmodule

// ---- ecwas_cfg.svh ----
// Purpose: constants of the indirect window and error status block
// Assumes: offsets are byte addresses of aligned doublewords
// Notes:   included by its bare name, guarded against double inclusion
`ifndef ECWAS_CFG_SVH
`define ECWAS_CFG_SVH

// register byte offsets
`define ECWAS_OFF_ADDR   12'h0F8
`define ECWAS_OFF_DATA   12'h0FC
`define ECWAS_OFF_CAP    12'h100
`define ECWAS_OFF_STAT   12'h104
`define ECWAS_OFF_MASK   12'h108

// indirect address fields and reset
`define ECWAS_REG_LSB    2
`define ECWAS_REG_MSB    7
`define ECWAS_EXTENDED_SELECT_LSB   8
`define ECWAS_EXTENDED_SELECT_MSB   11
`define ECWAS_ADDR_WMASK 32'h0000_0FFC
`define ECWAS_ADDR_RST   32'h0000_0000

// capability header fields
`define ECWAS_CAP_ID     16'h0001
`define ECWAS_CAP_VER    4'h1
`define ECWAS_NXT_RST    12'h200
`define ECWAS_NXT_LSB    20

// error status and mask bit positions
`define ECWAS_B_DLP      4
`define ECWAS_B_SDN      5
`define ECWAS_B_PSN      12
`define ECWAS_B_FCP      13
`define ECWAS_B_CTO      14
`define ECWAS_B_CAB      15
`define ECWAS_B_UEC      16
`define ECWAS_B_ROV      17
`define ECWAS_B_MAL      18
`define ECWAS_B_ECRC     19
`define ECWAS_B_UR       20
`define ECWAS_ERR_WMASK  32'h001F_3031
`define ECWAS_STAT_RST   32'h0000_0000
`define ECWAS_MASK_RST   32'h0000_0000

`endif

// ---- ecwas_pkg.sv ----
// Purpose: shared types of the indirect window and error status block
// Assumes: nothing
// Notes:   constants live in ecwas_cfg.svh
package ecwas_pkg;
    typedef logic [31:0] ecwas_word_t;
    typedef logic [11:0] ecwas_addr_t;
    typedef logic [3:0]  ecwas_be_t;
    typedef logic [11:0] ecwas_ptr_t;
    typedef enum logic [2:0] {
        tgt_none,
        tgt_addr,
        tgt_null,
        tgt_cap,
        tgt_stat,
        tgt_mask
    } ecwas_tgt_t;
endpackage

// ---- ecwas_acc_if.sv ----
// Purpose: resolved register access between the top and its register files
// Assumes: one access per cycle, already indirection-resolved
// Notes:   bmask is the byte enables widened to bits
interface ecwas_acc_if;
    import ecwas_pkg::*;
    logic        wr_stb;
    ecwas_addr_t addr;
    ecwas_word_t bmask;
    ecwas_word_t wdata;
    ecwas_word_t addr_q;
    ecwas_ptr_t  next_capability_pointer_q;
    ecwas_word_t status_q;
    ecwas_word_t mask_q;
    modport ctl  (output wr_stb, addr, bmask, wdata,
                  input  addr_q, next_capability_pointer_q, status_q, mask_q);
    modport errs (input  wr_stb, addr, bmask, wdata,
                  output status_q, mask_q);
    modport win  (input  wr_stb, addr, bmask, wdata,
                  output addr_q, next_capability_pointer_q);
endinterface

// ---- ecwas_win_regs.sv ----
// Purpose: indirect address register and lockable next pointer
// Assumes: srst is the ordinary synchronous reset
// Notes:   neither register is sticky
`include "ecwas_cfg.svh"
module ecwas_win_regs (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // register access
    ecwas_acc_if.win  acc,
    // write lock of the next pointer
    input  wire logic nxt_lock
);
    import ecwas_pkg::*;

    localparam ecwas_word_t ADDR_WMASK = `ECWAS_ADDR_WMASK;
    localparam int          NL         = `ECWAS_NXT_LSB;

    ecwas_word_t addr_ff;
    ecwas_word_t nxt_addr;
    ecwas_ptr_t  ptr_ff;
    ecwas_ptr_t  nxt_ptr;
    logic        addr_wr;
    logic        cap_wr;

    assign addr_wr      = acc.wr_stb && (acc.addr == `ECWAS_OFF_ADDR);
    assign cap_wr       = acc.wr_stb && (acc.addr == `ECWAS_OFF_CAP);
    assign acc.addr_q   = addr_ff;
    assign acc.next_capability_pointer_q = ptr_ff;

    always_comb begin
        nxt_addr = addr_ff;
        nxt_ptr  = ptr_ff;
        if (addr_wr) begin
            nxt_addr = ((addr_ff & ~acc.bmask) | (acc.wdata & acc.bmask))
                       & ADDR_WMASK;
        end
        if (cap_wr && !nxt_lock) begin
            nxt_ptr = (ptr_ff & ~acc.bmask[31:NL])
                      | (acc.wdata[31:NL] & acc.bmask[31:NL]);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            addr_ff <= `ECWAS_ADDR_RST;
            ptr_ff  <= `ECWAS_NXT_RST;
        end else begin
            addr_ff <= nxt_addr;
            ptr_ff  <= nxt_ptr;
        end
    end

    a_addr_rsvd_zero: assert property (
        @(posedge clk) disable iff (srst)
        (addr_ff & ~ADDR_WMASK) == '0)
        else $error("address register reserved bits set");

    a_ptr_lock_hold: assert property (
        @(posedge clk) disable iff (srst)
        (cap_wr && nxt_lock) |=> $stable(ptr_ff))
        else $error("locked next pointer changed");
endmodule

// ---- ecwas_err_bits.sv ----
// Purpose: sticky uncorrectable error status and mask registers
// Assumes: por_rst is asserted only at power-on
// Notes:   the ordinary reset does not touch these bits
`include "ecwas_cfg.svh"
module ecwas_err_bits (
    // clock and sticky reset
    input  wire logic                   clk,
    input  wire logic                   por_rst,
    // register access
    ecwas_acc_if.errs                   acc,
    // detected errors and capability
    input  wire ecwas_pkg::ecwas_word_t err_evt,
    input  wire logic                   sd_capable,
    // unmasked events, one-cycle pulses
    output ecwas_pkg::ecwas_word_t      report_ff
);
    import ecwas_pkg::*;

    localparam ecwas_word_t WMASK = `ECWAS_ERR_WMASK;
    localparam int          SDN   = `ECWAS_B_SDN;
    localparam int          DLP   = `ECWAS_B_DLP;

    ecwas_word_t stat_ff;
    ecwas_word_t mask_ff;
    ecwas_word_t nxt_stat;
    ecwas_word_t nxt_mask;
    ecwas_word_t nxt_report;
    ecwas_word_t set_v;
    ecwas_word_t clr_v;
    logic        stat_wr;
    logic        mask_wr;

    assign stat_wr      = acc.wr_stb && (acc.addr == `ECWAS_OFF_STAT);
    assign mask_wr      = acc.wr_stb && (acc.addr == `ECWAS_OFF_MASK);
    assign acc.status_q = stat_ff;
    assign acc.mask_q   = mask_ff;

    always_comb begin
        set_v = err_evt & WMASK;
        if (!sd_capable) begin
            set_v[SDN] = 1'b0;
        end
        clr_v = stat_wr ? (acc.bmask & acc.wdata) : '0;
        // an event in the clearing cycle survives the clear
        nxt_stat = ((stat_ff & ~clr_v) | set_v) & WMASK;
        if (!sd_capable) begin
            nxt_stat[SDN] = 1'b0;
        end
        nxt_mask = mask_ff;
        if (mask_wr) begin
            nxt_mask = ((mask_ff & ~acc.bmask) | (acc.wdata & acc.bmask))
                       & WMASK;
        end
        nxt_report = set_v & ~mask_ff;
    end

    always_ff @(posedge clk) begin
        if (por_rst) begin
            stat_ff   <= `ECWAS_STAT_RST;
            mask_ff   <= `ECWAS_MASK_RST;
            report_ff <= '0;
        end else begin
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            report_ff <= nxt_report;
        end
    end

    a_set_beats_clear: assert property (
        @(posedge clk) disable iff (por_rst)
        (err_evt[DLP] && stat_wr && acc.bmask[DLP] && acc.wdata[DLP])
        |=> stat_ff[DLP])
        else $error("event lost against clear");

    a_w1c_clears: assert property (
        @(posedge clk) disable iff (por_rst)
        (stat_wr && acc.bmask[DLP] && acc.wdata[DLP] && !err_evt[DLP])
        |=> !stat_ff[DLP])
        else $error("write one did not clear");

    a_sd_gated: assert property (
        @(posedge clk) disable iff (por_rst)
        !sd_capable |=> !stat_ff[SDN])
        else $error("surprise down set while not capable");

    a_mask_report: assert property (
        @(posedge clk) disable iff (por_rst)
        err_evt[DLP] |=> (report_ff[DLP] == !$past(mask_ff[DLP]))
                         && stat_ff[DLP])
        else $error("masking of link protocol error wrong");
endmodule

// ---- ecwas_rc_model.sv ----
// Purpose: root complex side, issues configuration requests
// Assumes: tasks are entered at a rising edge of clk
// Notes:   xfer leaves the request up so requests can run back to back
module ecwas_rc_model (
    // clock
    input  wire logic                   clk,
    // configuration requests
    output logic                        cfg_req,
    output logic                        cfg_wr,
    output logic                        cfg_smbus,
    output ecwas_pkg::ecwas_addr_t      cfg_addr,
    output ecwas_pkg::ecwas_be_t        cfg_be,
    output ecwas_pkg::ecwas_word_t      cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecwas_pkg::*;
    initial begin
        cfg_req   = 1'b0;
        cfg_wr    = 1'b0;
        cfg_smbus = 1'b0;
        cfg_addr  = 12'h000;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    task automatic xfer(input logic wr, input logic smb, input ecwas_addr_t a,
                        input ecwas_be_t be, input ecwas_word_t d);
        #1;
        cfg_req   = 1'b1;
        cfg_wr    = wr;
        cfg_smbus = smb;
        cfg_addr  = a;
        cfg_be    = be;
        cfg_wdata = d;
        @(posedge clk);
    endtask
    // released lines flip so a stale value is never mistaken for a request
    task automatic idle();
        #1;
        cfg_req   = 1'b0;
        cfg_wr    = ~cfg_wr;
        cfg_smbus = ~cfg_smbus;
        cfg_addr  = ~cfg_addr;
        cfg_be    = ~cfg_be;
        cfg_wdata = ~cfg_wdata;
        @(posedge clk);
    endtask
endmodule

// ---- tb_ecwas_top.sv ----
// Purpose: self-checking bench of the indirect window and error status
// Assumes: every request is answered one cycle after it is taken
// Notes:   answers are checked against a queue of expected read data
`include "ecwas_cfg.svh"
module tb_ecwas_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ecwas_pkg::*;
    localparam int BPOS [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};
    logic        clk, srst, por_rst, lock, sdc, ack, req, wr, smb;
    logic [8:0]  ev;
    ecwas_addr_t addr;
    ecwas_be_t   be, bb;
    ecwas_word_t wdata, rdata, rep, r, a_exp;
    ecwas_word_t exp_q[$];
    logic [31:0] seed = 32'h0000_F891;
    int          n_errors = 0;
    int          compares = 0;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ecwas_rc_model rc (.clk(clk), .cfg_req(req), .cfg_wr(wr),
        .cfg_smbus(smb), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata));

    ecwas_top dut (.clk(clk), .srst(srst), .por_rst(por_rst),
        .cfg_req(req), .cfg_wr(wr), .cfg_smbus(smb), .cfg_addr(addr),
        .cfg_be(be), .cfg_wdata(wdata), .cfg_ack_ff(ack),
        .cfg_rdata_ff(rdata), .nxt_ptr_lock(lock),
        .surprise_down_capable(sdc), .evt_link_protocol_error(ev[0]),
        .evt_surprise_down_error(ev[1]), .evt_poisoned_tlp(ev[2]),
        .evt_flow_control_error(ev[3]), .evt_unexpected_completion(ev[4]),
        .evt_receiver_overflow(ev[5]), .evt_malformed_tlp(ev[6]),
        .evt_ecrc_error(ev[7]), .evt_unsupported_request(ev[8]),
        .err_report_ff(rep));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic ecwas_word_t bm(input ecwas_be_t b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    task automatic chk(input ecwas_word_t got, input ecwas_word_t exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // writes answer zero; reads answer e
    task automatic acc(input logic w, input logic s, input ecwas_addr_t a,
                       input ecwas_be_t b, input ecwas_word_t d,
                       input ecwas_word_t e);
        exp_q.push_back(w ? 32'h0000_0000 : e);
        rc.xfer(w, s, a, b, d);
    endtask
    // one event pulse, then the report seen one cycle later
    task automatic fire(input int i, input ecwas_word_t e);
        #1;
        ev = 9'h001 << i;
        @(posedge clk);
        #1;
        ev = 9'h000;
        chk(rep, e);
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] %0t answer without request", $time);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        #(20000 * 4);
        n_errors++;
        close_out();
    end

    initial begin
        srst = 1'b1;
        por_rst = 1'b1;
        lock = 1'b0;
        sdc = 1'b1;
        ev = 9'h000;
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        por_rst = 1'b0;
        @(posedge clk);
        acc(0, 0, `ECWAS_OFF_ADDR, 4'hF, 0, 32'h0000_0000);
        acc(0, 0, `ECWAS_OFF_CAP, 4'hF, 0, 32'h2001_0001);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h0000_0000);
        acc(0, 0, `ECWAS_OFF_MASK, 4'hF, 0, 32'h0000_0000);
        acc(0, 0, 12'h10C, 4'hF, 0, 32'h0000_0000);
        a_exp = 32'h0000_0000;
        for (int k = 0; k < 8; k++) begin
            r = xs();
            bb = ecwas_be_t'(xs());
            a_exp = (a_exp & ~bm(bb)) | (r & bm(bb) & 32'h0000_0FFC);
            acc(1, 0, `ECWAS_OFF_ADDR, bb, r, 0);
            acc(0, 0, `ECWAS_OFF_ADDR, 4'hF, 0, a_exp);
        end
        rc.idle();
        for (int i = 0; i < 9; i++)
            fire(i, 32'h1 << BPOS[i]);
        acc(1, 0, `ECWAS_OFF_ADDR, 4'hF, 32'h104, 0);
        acc(0, 0, `ECWAS_OFF_DATA, 4'hF, 0, 32'h001F_3030);
        acc(0, 0, `ECWAS_OFF_DATA, 4'h4, 0, 32'h001F_0000);
        acc(1, 0, `ECWAS_OFF_DATA, 4'h3, 32'h0000_1010, 0);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h001F_2020);
        rc.idle();
        #1;
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        @(posedge clk);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h001F_2020);
        acc(0, 0, `ECWAS_OFF_ADDR, 4'hF, 0, 32'h0000_0000);
        acc(1, 0, `ECWAS_OFF_STAT, 4'hF, 32'hFFFF_FFFF, 0);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h0000_0000);
        acc(1, 0, `ECWAS_OFF_MASK, 4'hF, 32'hFFFF_FFFF, 0);
        acc(0, 0, `ECWAS_OFF_MASK, 4'hF, 0, 32'h001F_3031);
        rc.idle();
        for (int i = 0; i < 9; i++)
            fire(i, 32'h0000_0000);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h001F_3030);
        acc(1, 0, `ECWAS_OFF_STAT, 4'hF, 32'hFFFF_FFFF, 0);
        rc.idle();
        #1;
        sdc = 1'b0;
        @(posedge clk);
        fire(1, 32'h0000_0000);
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h0000_0000);
        // event and write-one clear land on the same edge: the set wins
        fork
            begin
                acc(1, 0, `ECWAS_OFF_STAT, 4'hF, 32'h0000_0010, 0);
                rc.idle();
            end
            fire(0, 32'h0000_0000);
        join
        acc(0, 0, `ECWAS_OFF_STAT, 4'hF, 0, 32'h0000_0010);
        acc(1, 0, `ECWAS_OFF_ADDR, 4'hF, 32'h0FC, 0);
        acc(0, 0, `ECWAS_OFF_DATA, 4'hF, 0, 32'h0000_0000);
        acc(1, 0, `ECWAS_OFF_DATA, 4'hF, 32'h108, 0);
        acc(0, 0, `ECWAS_OFF_ADDR, 4'hF, 0, 32'h0000_00FC);
        acc(1, 0, `ECWAS_OFF_ADDR, 4'hF, 32'h0F8, 0);
        acc(1, 0, `ECWAS_OFF_DATA, 4'hF, 32'h108, 0);
        acc(0, 0, `ECWAS_OFF_ADDR, 4'hF, 0, 32'h0000_0108);
        acc(0, 1, `ECWAS_OFF_DATA, 4'hF, 0, 32'h0000_0000);
        acc(1, 1, `ECWAS_OFF_DATA, 4'hF, 32'h0, 0);
        acc(0, 0, `ECWAS_OFF_DATA, 4'hF, 0, 32'h001F_3031);
        acc(1, 0, `ECWAS_OFF_DATA, 4'hF, 32'h0000_1010, 0);
        acc(0, 0, `ECWAS_OFF_MASK, 4'hF, 0, 32'h0000_1010);
        rc.idle();
        #1;
        lock = 1'b1;
        @(posedge clk);
        acc(1, 0, `ECWAS_OFF_CAP, 4'hF, 32'hFFFF_FFFF, 0);
        acc(0, 0, `ECWAS_OFF_CAP, 4'hF, 0, 32'h2001_0001);
        rc.idle();
        #1;
        lock = 1'b0;
        @(posedge clk);
        acc(1, 0, `ECWAS_OFF_CAP, 4'hC, 32'h3005_0000, 0);
        acc(0, 0, `ECWAS_OFF_CAP, 4'hF, 0, 32'h3001_0001);
        acc(1, 0, `ECWAS_OFF_ADDR, 4'hF, 32'h100, 0);
        acc(0, 0, `ECWAS_OFF_DATA, 4'h1, 0, 32'h0000_0001);
        rc.idle();
        #1;
        por_rst = 1'b1;
        @(posedge clk);
        #1;
        por_rst = 1'b0;
        @(posedge clk);
        acc(0, 0, `ECWAS_OFF_MASK, 4'hF, 0, 32'h0000_0000);
        rc.idle();
        repeat (2) @(posedge clk);
        chk(exp_q.size(), 32'h0000_0000);
        close_out();
    end
endmodule
